// [src/sasp_consts.svh]
// Field positions, reset values and timing counts of the sequencer port
`ifndef SASP_CONSTS_SVH
`define SASP_CONSTS_SVH

`define SASP_CLK_PERIOD_NS  40
`define SASP_CONV_CYCLES    14
`define SASP_EOC_MIN_NS     75
`define SASP_EOC_MAX_NS     180
`define SASP_EOC_CYC        ((`SASP_EOC_MIN_NS + `SASP_CLK_PERIOD_NS - 1) / `SASP_CLK_PERIOD_NS)
`define SASP_INT_CLK_DIV    2
`define SASP_NUM_CHAN       4
`define SASP_CODE_W         12
`define SASP_SEL_LSB        0
`define SASP_SEL_MSB        3
`define SASP_SEL_RESET      4'h0
`define SASP_CODE_MSB       11
`define SASP_SYNC_W         16

`endif

// [src/sasp_pkg.sv]
// Types shared by the sequencer port files
package sasp_pkg;
    typedef logic [11:0] sasp_code_t;
    typedef logic [3:0]  sasp_sel_t;
    typedef logic [1:0]  sasp_chan_t;
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_PUSH  = 4'b0100,
        ST_DRAIN = 4'b1000
    } sasp_state_e;
endpackage : sasp_pkg

// [src/sasp_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sasp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage1_r;

    generate
        if (W < 1)
        begin : g_chk
            $error("sasp_sync: W must be at least 1");
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage1_r <= '0;
            o_sync   <= '0;
        end
        else
        begin
            stage1_r <= i_async;
            o_sync   <= stage1_r;
        end
    end
endmodule : sasp_sync

// [src/sasp_fifo.sv]
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sasp_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0]   count_r;
    wire           push;
    wire           pop;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_chk
            $error("sasp_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    assign o_in_ready  = (count_r != DEPTH[AW:0]);
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem_r[rptr_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_r[wptr_r] <= i_in_data;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end
        else
        begin
            wptr_r  <= push ? wptr_r + 1'b1 : wptr_r;
            rptr_r  <= pop ? rptr_r + 1'b1 : rptr_r;
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : sasp_fifo

// [src/sasp_top.sv]
// Sequencer and parallel port of the four-channel simultaneous converter
`timescale 1ns/1ps
`include "sasp_consts.svh"
module sasp_top #(
    parameter int INT_CLK_DIV = `SASP_INT_CLK_DIV,
    parameter int CONV_CYCLES = `SASP_CONV_CYCLES,
    parameter bit BIPOLAR     = 1'b1,
    parameter int BUF_DEPTH   = 2
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_CONVERSION_TRIGGER,
    input  wire logic        I_CS_N,
    input  wire logic        I_RD_N,
    input  wire logic        I_WR_N,
    input  wire logic [3:0]  I_CHANNEL_PICK_PINS,
    input  wire logic        I_SELECT_SOURCE,
    input  wire logic        I_POWER_SAVE_N,
    input  wire logic        I_CLOCK_SOURCE_SELECT,
    input  wire logic        I_EXTERNAL_CONVERSION_CLOCK,
    input  wire logic [3:0]  I_SHARED_SELECT_LINES,
    input  wire logic [11:0] I_CORE_CODE,
    output logic [5:0]       O_RESULT_BUS_HIGH,
    output logic [1:0]       O_RESULT_BUS_MID,
    output logic [3:0]       O_SHARED_SELECT_LINES,
    output logic             O_DATA_OE,
    output logic             O_BUSY,
    output logic             O_EOC_N,
    output logic             O_FIRST_RESULT_FLAG,
    output logic             O_HOLD,
    output logic [1:0]       O_CORE_CHANNEL,
    output logic             O_STANDBY
);
    localparam int NCH  = `SASP_NUM_CHAN;
    localparam int CW   = `SASP_CODE_W;
    localparam int EOCC = `SASP_EOC_CYC;
    localparam int BW   = CW + 2;

    generate
        if (INT_CLK_DIV < 1 || INT_CLK_DIV > 255)
        begin : g_chk_div
            $error("sasp_top: INT_CLK_DIV out of range 1..255");
        end
        if (CONV_CYCLES < 2 || CONV_CYCLES > 15)
        begin : g_chk_conv
            $error("sasp_top: CONV_CYCLES out of range 2..15");
        end
        if (EOCC < 1 || EOCC > 7)
        begin : g_chk_eoc
            $error("sasp_top: end-of-conversion pulse length out of range");
        end
        if (NCH != 4)
        begin : g_chk_nch
            $error("sasp_top: sequencer serves exactly four channels");
        end
        if (CW != 12)
        begin : g_chk_cw
            $error("sasp_top: result width must match the 12-bit bus");
        end
        if (BUF_DEPTH < 2)
        begin : g_chk_buf
            $error("sasp_top: BUF_DEPTH must be at least 2");
        end
    endgenerate

    // Lowest selected channel at or above a start index
    function automatic logic [2:0] next_chan(input sasp_pkg::sasp_sel_t sel,
                                             input logic [2:0] from);
        logic [2:0] res;
        res = 3'h4;
        for (int k = NCH - 1; k >= 0; k--)
        begin
            if (sel[k] && (k >= int'(from)))
                res = 3'(k);
        end
        return res;
    endfunction : next_chan

    // All pins pass two flops; bus lines share the stage so data aligns with strobes
    // Active-low pins travel inverted so the flops' reset value reads as idle
    logic [`SASP_SYNC_W-1:0] pins_s;
    wire  [`SASP_SYNC_W-1:0] pins_a;
    assign pins_a = {I_CONVERSION_TRIGGER, ~I_CS_N, ~I_RD_N, ~I_WR_N, I_CHANNEL_PICK_PINS,
                     I_SELECT_SOURCE, ~I_POWER_SAVE_N, I_CLOCK_SOURCE_SELECT,
                     I_EXTERNAL_CONVERSION_CLOCK, I_SHARED_SELECT_LINES};

    sasp_sync #(
        .W (`SASP_SYNC_W)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_async (pins_a),
        .o_sync  (pins_s)
    );

    wire                 trig_s  = pins_s[15];
    wire                 cs_n_s  = ~pins_s[14];
    wire                 rd_n_s  = ~pins_s[13];
    wire                 wr_n_s  = ~pins_s[12];
    wire [3:0]           pick_s  = pins_s[11:8];
    wire                 src_s   = pins_s[7];
    wire                 psave_s = ~pins_s[6];
    wire                 csel_s  = pins_s[5];
    wire                 xclk_s  = pins_s[4];
    wire [3:0]           dbin_s  = pins_s[3:0];

    // Edge detectors reset to each pin's idle level so no edge follows reset
    logic                trig_d_r;
    logic                rd_d_r;
    logic                wr_d_r;
    logic                xclk_d_r;
    logic [7:0]          div_r;
    sasp_pkg::sasp_sel_t chan_sel_r;
    sasp_pkg::sasp_sel_t seq_sel_r;
    sasp_pkg::sasp_state_e state_r;
    sasp_pkg::sasp_state_e state_nxt;
    logic [2:0]          chan_r;
    logic [3:0]          cyc_r;
    logic [2:0]          eoc_cnt_r;
    logic [1:0]          rd_ptr_r;
    logic [1:0]          wr_idx_r;
    sasp_pkg::sasp_code_t result_mem_r [NCH];
    sasp_pkg::sasp_code_t dout_r;
    sasp_pkg::sasp_code_t code_r;

    wire trig_rise = trig_s & ~trig_d_r;
    wire active    = psave_s;
    wire read_on   = ~cs_n_s & ~rd_n_s;
    wire read_done = ~cs_n_s & rd_n_s & ~rd_d_r;
    wire wr_rise   = ~cs_n_s & rd_n_s & wr_n_s & ~wr_d_r;
    wire int_tick  = (div_r == 8'(INT_CLK_DIV - 1));
    wire ext_tick  = xclk_s & ~xclk_d_r;
    wire conv_tick = active & (csel_s ? ext_tick : int_tick);
    wire [3:0] live_sel = src_s ? chan_sel_r : pick_s;
    wire [2:0] first_ch = next_chan(live_sel, 3'h0);
    wire [2:0] after_ch = next_chan(seq_sel_r, chan_r + 3'h1);
    wire       is_idle  = (state_r == sasp_pkg::ST_IDLE);
    wire       in_conv  = (state_r == sasp_pkg::ST_CONV);
    wire       in_push  = (state_r == sasp_pkg::ST_PUSH);
    // A trigger during a sequence is dropped, not queued
    wire       start    = is_idle & trig_rise & active;
    wire       conv_end = in_conv & conv_tick
                          & (cyc_r == 4'(CONV_CYCLES - 1));

    // Unipolar coding passes the core's offset binary; bipolar flips the sign bit
    wire sasp_pkg::sasp_code_t coded =
        BIPOLAR ? {~I_CORE_CODE[`SASP_CODE_MSB], I_CORE_CODE[CW-2:0]}
                : I_CORE_CODE;

    wire          buf_in_valid = in_push;
    wire          buf_in_ready;
    wire          buf_out_valid;
    wire [BW-1:0] buf_out_data;
    // Drain held off during a read so no result is written to the result registers while the bus is driven
    wire          buf_out_ready = ~read_on;
    wire          store = buf_out_valid & buf_out_ready;

    // Registered outputs take their next values from these
    wire       run_nxt  = (state_nxt != sasp_pkg::ST_IDLE) & active;
    wire       eoc_low  = conv_end | (eoc_cnt_r > 3'h1);
    wire       ptr_wrap = (rd_ptr_r == 2'h3);
    wire       flag_nxt = start | (read_done ? ptr_wrap : (rd_ptr_r == 2'h0));
    wire [1:0] ch_nxt   = start ? first_ch[1:0] : chan_r[1:0];

    sasp_fifo #(
        .W     (BW),
        .DEPTH (BUF_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_rst       (I_RST),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (buf_in_ready),
        .i_in_data   ({chan_r[1:0], code_r}),
        .o_out_valid (buf_out_valid),
        .i_out_ready (buf_out_ready),
        .o_out_data  (buf_out_data)
    );

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sasp_pkg::ST_IDLE:
                if (start && first_ch != 3'h4)
                    state_nxt = sasp_pkg::ST_CONV;
            sasp_pkg::ST_CONV:
                if (conv_end)
                    state_nxt = sasp_pkg::ST_PUSH;
            sasp_pkg::ST_PUSH:
                if (buf_in_ready)
                    state_nxt = (after_ch == 3'h4) ? sasp_pkg::ST_DRAIN
                                                   : sasp_pkg::ST_CONV;
            sasp_pkg::ST_DRAIN:
                if (!buf_out_valid)
                    state_nxt = sasp_pkg::ST_IDLE;
            default:
                state_nxt = sasp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            trig_d_r <= 1'b0;
            rd_d_r   <= 1'b1;
            wr_d_r   <= 1'b1;
            xclk_d_r <= 1'b0;
            div_r    <= 8'h00;
            state_r  <= sasp_pkg::ST_IDLE;
        end
        else
        begin
            trig_d_r <= trig_s;
            rd_d_r   <= rd_n_s;
            wr_d_r   <= wr_n_s;
            xclk_d_r <= xclk_s;
            div_r    <= int_tick ? 8'h00 : div_r + 8'h01;
            state_r  <= active ? state_nxt : sasp_pkg::ST_IDLE;
        end
    end

    // Write-only select register
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            chan_sel_r <= `SASP_SEL_RESET;
        else if (wr_rise)
            chan_sel_r <= dbin_s[`SASP_SEL_MSB:`SASP_SEL_LSB];
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            seq_sel_r <= 4'h0;
            chan_r    <= 3'h0;
            cyc_r     <= 4'h0;
            code_r    <= 12'h000;
        end
        else if (start)
        begin
            seq_sel_r <= live_sel;
            chan_r    <= first_ch;
            cyc_r     <= 4'h0;
        end
        else if (in_conv && conv_tick)
        begin
            cyc_r <= conv_end ? 4'h0 : cyc_r + 4'h1;
            if (conv_end)
                code_r <= coded;
        end
        else if (in_push && buf_in_ready)
            chan_r <= after_ch;
    end

    // Low pulse of fixed width per finished conversion
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            eoc_cnt_r <= 3'h0;
        else if (conv_end)
            eoc_cnt_r <= 3'(EOCC);
        else if (eoc_cnt_r != 3'h0)
            eoc_cnt_r <= eoc_cnt_r - 3'h1;
    end

    // Result registers and read pointer
    // Pointer wraps after four reads; reading past the last result repeats old words
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            rd_ptr_r <= 2'h0;
            wr_idx_r <= 2'h0;
        end
        else if (start)
        begin
            rd_ptr_r <= 2'h0;
            wr_idx_r <= 2'h0;
        end
        else
        begin
            if (read_done)
                rd_ptr_r <= rd_ptr_r + 2'h1;
            if (store)
                wr_idx_r <= wr_idx_r + 2'h1;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (store)
            result_mem_r[wr_idx_r] <= buf_out_data[CW-1:0];
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            dout_r              <= 12'h000;
            O_BUSY              <= 1'b0;
            O_EOC_N             <= 1'b1;
            O_FIRST_RESULT_FLAG <= 1'b1;
            O_HOLD              <= 1'b0;
            O_CORE_CHANNEL      <= 2'h0;
            O_STANDBY           <= 1'b0;
        end
        else
        begin
            dout_r              <= result_mem_r[rd_ptr_r];
            O_BUSY              <= run_nxt;
            O_EOC_N             <= ~eoc_low;
            O_FIRST_RESULT_FLAG <= flag_nxt;
            O_HOLD              <= run_nxt;
            O_CORE_CHANNEL      <= ch_nxt;
            O_STANDBY           <= ~active;
        end
    end

    assign O_RESULT_BUS_HIGH     = dout_r[11:6];
    assign O_RESULT_BUS_MID      = dout_r[5:4];
    assign O_SHARED_SELECT_LINES = dout_r[3:0];
    assign O_DATA_OE             = read_on;
endmodule : sasp_top

// [testbench/sasp_assertions.sv]
// Concurrent checks on the pins of the sequencer port
`timescale 1ns/1ps
module sasp_assertions (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CONVERSION_TRIGGER,
    input wire logic I_CS_N,
    input wire logic I_RD_N,
    input wire logic I_POWER_SAVE_N,
    input wire logic I_CLOCK_SOURCE_SELECT,
    input wire logic O_DATA_OE,
    input wire logic O_BUSY,
    input wire logic O_EOC_N,
    input wire logic O_FIRST_RESULT_FLAG,
    input wire logic O_HOLD,
    input wire logic O_STANDBY
);
    localparam int CONV_LO = 26;
    localparam int CONV_HI = 33;
    logic [2:0] arm_r;
    logic [7:0] gap_r;
    // Two-deep past values mean nothing until a few edges after reset
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            arm_r <= 3'h0;
        else if (arm_r != 3'h7)
            arm_r <= arm_r + 3'h1;
    end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            gap_r <= 8'h00;
        else if ($rose(O_BUSY) || $fell(O_EOC_N))
            gap_r <= 8'h00;
        else if (gap_r != 8'hFF)
            gap_r <= gap_r + 8'h01;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST || arm_r != 3'h7);
    sequence rd_seen;
        $past(!I_CS_N, 2) && $past(!I_RD_N, 2);
    endsequence
    sequence eoc_tail;
        !O_EOC_N ##1 O_EOC_N;
    endsequence
    oe_gate_a: assert property (O_DATA_OE |-> rd_seen)
        else $error("data bus driven without select and read");
    oe_drive_a: assert property (rd_seen |-> O_DATA_OE)
        else $error("data bus not driven during read");
    cs_gate_a: assert property (I_CS_N [*3] |-> !O_DATA_OE)
        else $error("read answered while deselected");
    busy_start_a: assert property ($rose(O_BUSY) |-> O_HOLD && $past(I_CONVERSION_TRIGGER, 2))
        else $error("busy rose without trigger or hold");
    eoc_width_a: assert property ($fell(O_EOC_N) |=> eoc_tail)
        else $error("end pulse width wrong");
    eoc_busy_a: assert property (!O_EOC_N |-> O_BUSY)
        else $error("end pulse outside sequence");
    conv_len_a: assert property ($fell(O_EOC_N) && !I_CLOCK_SOURCE_SELECT
        |-> gap_r >= CONV_LO && gap_r <= CONV_HI)
        else $error("conversion length wrong");
    first_flag_a: assert property ($rose(O_BUSY) |-> ##[0:2] O_FIRST_RESULT_FLAG)
        else $error("first flag not set at start");
    standby_on_a: assert property (!I_POWER_SAVE_N [*6] |-> O_STANDBY && !O_BUSY)
        else $error("standby not entered");
endmodule : sasp_assertions

bind sasp_top sasp_assertions i_chk (.I_CLK, .I_RST, .I_CONVERSION_TRIGGER, .I_CS_N, .I_RD_N,
    .I_POWER_SAVE_N, .I_CLOCK_SOURCE_SELECT, .O_DATA_OE, .O_BUSY, .O_EOC_N,
    .O_FIRST_RESULT_FLAG, .O_HOLD, .O_STANDBY);

// [testbench/sasp_core_model.sv]
// Analog core stand-in and external conversion clock source
`timescale 1ns/1ps
module sasp_core_model #(
    parameter int EXT_HALF = 4
) (
    input  wire logic        i_clk,
    input  wire logic        i_ext_en,
    input  wire logic [1:0]  i_channel,
    input  wire logic [11:0] i_base,
    output logic      [11:0] o_code,
    output logic             o_ext_clk
);
    logic [3:0] ph_r;
    // Distinct code per channel exposes ordering slips
    assign o_code = i_base + 12'h111 * {10'h000, i_channel};
    // Even halves keep the duty cycle at 50/50; idle low between frames
    always_ff @(posedge i_clk)
    begin
        if (!i_ext_en)
        begin
            ph_r      <= 4'h0;
            o_ext_clk <= 1'b0;
        end
        else if (ph_r == 4'(EXT_HALF - 1))
        begin
            ph_r      <= 4'h0;
            o_ext_clk <= ~o_ext_clk;
        end
        else
            ph_r <= ph_r + 4'h1;
    end
endmodule : sasp_core_model

// [testbench/sasp_top_tb.sv]
// Self-checking bench for the sequencer port
`timescale 1ns/1ps
module sasp_top_tb;
    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    logic        trig   = 1'b0;
    logic        cs_n   = 1'b1;
    logic        rd_n   = 1'b1;
    logic        wr_n   = 1'b1;
    logic [3:0]  pins   = 4'h0;
    logic        src    = 1'b0;
    logic        psn    = 1'b1;
    logic        csel   = 1'b0;
    logic [3:0]  wdata  = 4'h0;
    logic [11:0] base   = 12'h000;
    logic        ext_en = 1'b0;
    logic        eoc_d  = 1'b1;
    logic [11:0] code;
    logic [11:0] junk;
    logic [5:0]  hi;
    logic [1:0]  mid;
    logic [1:0]  chan;
    logic [3:0]  lo;
    logic [3:0]  dbus;
    logic [3:0]  rsel;
    logic        ext_clk, oe, busy, eoc_n, first, hold, power_save_n;
    int          err_total = 0;
    int          checked   = 0;
    int          seed      = 29187;
    int          eoc_cnt   = 0;

    always #20 clk = ~clk;
    assign dbus = oe ? lo : wdata;

    sasp_top i_dut (.I_CLK(clk), .I_RST(rst), .I_CONVERSION_TRIGGER(trig), .I_CS_N(cs_n),
        .I_RD_N(rd_n), .I_WR_N(wr_n), .I_CHANNEL_PICK_PINS(pins), .I_SELECT_SOURCE(src),
        .I_POWER_SAVE_N(psn), .I_CLOCK_SOURCE_SELECT(csel), .I_EXTERNAL_CONVERSION_CLOCK(ext_clk),
        .I_SHARED_SELECT_LINES(dbus), .I_CORE_CODE(code), .O_RESULT_BUS_HIGH(hi),
        .O_RESULT_BUS_MID(mid), .O_SHARED_SELECT_LINES(lo), .O_DATA_OE(oe), .O_BUSY(busy),
        .O_EOC_N(eoc_n), .O_FIRST_RESULT_FLAG(first), .O_HOLD(hold), .O_CORE_CHANNEL(chan),
        .O_STANDBY(power_save_n));
    sasp_core_model i_core (.i_clk(clk), .i_ext_en(ext_en), .i_channel(chan), .i_base(base),
        .o_code(code), .o_ext_clk(ext_clk));

    always @(posedge clk)
    begin
        eoc_d <= eoc_n;
        if (eoc_d && !eoc_n)
            eoc_cnt <= eoc_cnt + 1;
    end

    function automatic logic [11:0] exp_code(input logic [11:0] b, input int ch);
        return (b + 12'h111 * 12'(ch)) ^ 12'h800;
    endfunction : exp_code

    task automatic close_out();
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic cmp_word(input string what, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic write_reg(input logic [3:0] d, input logic c);
        @(posedge clk);
        cs_n  <= c;
        wdata <= d;
        cyc(3);
        wr_n <= 1'b0;
        cyc(3);
        wr_n <= 1'b1;
        cyc(4);
        cs_n <= 1'b1;
    endtask : write_reg

    // Write strobe stays high all through the read
    task automatic read_word(output logic [11:0] w, input logic c);
        @(posedge clk);
        cs_n <= c;
        rd_n <= 1'b0;
        cyc(5);
        @(negedge clk);
        w = {hi, mid, lo};
        cmp_bit("data_oe", !c, oe);
        @(posedge clk);
        rd_n <= 1'b1;
        cyc(3);
        cs_n <= 1'b1;
        cyc(2);
    endtask : read_word

    task automatic run_seq(input logic [3:0] sel, input logic s, input logic ext, input logic bad);
        logic [11:0] w;
        int k;
        k = 0;
        if (s)
            write_reg(sel, 1'b0);
        if (bad)
            write_reg(~sel, 1'b1);
        @(posedge clk);
        base   <= 12'($random(seed));
        pins   <= s ? ~sel : sel;
        src    <= s;
        csel   <= ext;
        ext_en <= ext;
        cyc(4);
        @(negedge clk);
        eoc_cnt = 0;
        @(posedge clk);
        trig <= 1'b1;
        cyc(6);
        trig <= 1'b0;
        pins <= ~pins;
        @(negedge clk);
        cmp_bit("busy", 1'b1, busy);
        if (s)
            write_reg(~sel, 1'b0);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(posedge clk);
        @(negedge clk);
        cmp_bit("busy", 1'b0, busy);
        cmp_word("eoc_count", 12'($countones(sel)), 12'(eoc_cnt));
        cmp_bit("first", 1'b1, first);
        @(posedge clk);
        ext_en <= 1'b0;
        for (int ch = 0; ch < 4; ch++)
        begin
            if (sel[ch])
            begin
                read_word(w, 1'b0);
                k++;
                cmp_word("result", exp_code(base, ch), w);
                cmp_bit("first", k == 4, first);
            end
        end
    endtask : run_seq

    initial
    begin
        cyc(6);
        rst <= 1'b0;
        cyc(4);
        run_seq(4'hF, 1'b0, 1'b0, 1'b0);
        run_seq(4'h1, 1'b1, 1'b0, 1'b1);
        run_seq(4'h8, 1'b0, 1'b0, 1'b0);
        run_seq(4'hF, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            rsel = 4'($random(seed));
            if (rsel == 4'h0)
                rsel = 4'h6;
            run_seq(rsel, 1'($random(seed)), 1'b0, 1'b0);
        end
        read_word(junk, 1'b1);
        @(posedge clk);
        pins <= 4'hF;
        src  <= 1'b0;
        trig <= 1'b1;
        cyc(30);
        psn <= 1'b0;
        cyc(8);
        @(negedge clk);
        cmp_bit("busy", 1'b0, busy);
        cmp_bit("standby", 1'b1, power_save_n);
        @(posedge clk);
        trig <= 1'b0;
        psn  <= 1'b1;
        cyc(8);
        @(negedge clk);
        cmp_bit("standby", 1'b0, power_save_n);
        run_seq(4'h5, 1'b0, 1'b0, 1'b0);
        close_out();
    end

    initial
    begin
        #(40 * 30000);
        err_total++;
        close_out();
    end
endmodule : sasp_top_tb
